// *** verilog/yig_cal_pkg.sv ***
// Constants, encodings and state types of the YIG DAC correction table
// Overview of operation
// RULE1 - Entry: two-byte frequency, then two-byte DAC
// RULE2 - Frequency stored as count of 2 MHz
// RULE3 - Table holds between 2 and 248 entries
// RULE4 - First and last entries are extrapolated values
// RULE5 - Exact DAC match returns stored frequency
// RULE6 - Between neighbours, interpolate frequency linearly
// RULE7 - Multiply fully before dividing in interpolation
// RULE8 - No fitting entry raises error 40
// RULE9 - Calibration starts with two default entries
// RULE10 - New point inserted below upper default
// RULE11 - Sweep, centre, then store DAC reading
// RULE12 - Operator supplies 2 to 246 points
// RULE13 - Each frequency above the previous one
// RULE14 - Bad count, order or centring aborts session
// RULE15 - End defaults replaced by extrapolation on exit
// RULE16 - Extrapolate from the two adjacent measured points
// RULE17 - Table at 0C00, ends with all-ones mark
// RULE18 - Table writes only while protect input high
// RULE19 - Prompt starts at one, steps per point
// RULE20 - Search or centring failure reports error 42
// RULE21 - Abort discards work, exit commits it
// RULE22 - Status bit 0 set when ready for next
// RULE23 - Truncating division, two-byte results
package yig_cal_pkg;
  // =======================================================
  // Table layout
  localparam int          FIELD_W      = 16;
  localparam int          MIN_ENTRIES  = 2;
  localparam int          MAX_ENTRIES  = 248;
  localparam int          MIN_POINTS   = 2;
  localparam int          MAX_POINTS   = 246;
  localparam logic [15:0] DEFAULT_LO   = 16'h0000;
  localparam logic [15:0] DEFAULT_HI   = 16'h3fff;
  localparam logic [31:0] END_MARK     = 32'hffff_ffff;
  localparam int          FREQ_SHIFT   = 1;
  // =======================================================
  // Memory map, word addressed
  localparam int          MEM_AW       = 10;
  localparam int          MEM_WORDS    = 1024;
  localparam logic [15:0] TABLE_BASE   = 16'h0c00;
  localparam logic [9:0]  COMMIT_BASE  = TABLE_BASE[11:2];
  localparam logic [9:0]  WORK_BASE    = 10'h000;
  // =======================================================
  // Codes shown to the user
  localparam logic [7:0]  ERR_TABLE    = 8'h28;
  localparam logic [7:0]  ERR_CENTER   = 8'h2a;
  localparam logic [7:0]  PROMPT_FIRST = 8'h01;
  localparam logic [7:0]  PROMPT_NONE  = 8'h00;
  localparam int          READY_BIT    = 0;
  // =======================================================
  // Controller states
  typedef enum {
    ST_IDLE, ST_LK_RD, ST_LK_CHK, ST_CAL_INIT, ST_CAL_HI,
    ST_CAL_WAIT, ST_CAL_SRCH, ST_CAL_STORE, ST_EXT_LO,
    ST_EXT_HI, ST_CP_RD, ST_CP_WR, ST_CP_MARK
  } state_t;
endpackage

// *** verilog/table_mem_if.sv ***
// Port bundle between the table controller and its memory
interface table_mem_if;
  logic [9:0]  addr;
  logic [31:0] wdata;
  logic        we;
  logic [31:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// *** verilog/yig_table_mem.sv ***
// Table memory: committed bank and working bank, registered read
module yig_table_mem
(
  input wire logic i_clk,
  table_mem_if.mem bus
);
  logic [31:0] store [0:yig_cal_pkg::MEM_WORDS-1];

  // =======================================================
  // Single port, registered read returns the old word during a write
  always_ff @(posedge i_clk)
  begin
    if (bus.we)
    begin
      store[bus.addr] <= bus.wdata;
    end
    bus.rdata <= store[bus.addr];
  end
endmodule // yig_table_mem

// *** verilog/yig_dac_correction_table.sv ***
// YIG DAC correction table: lookup and calibration controller
module yig_dac_correction_table
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_calibration_protect_switch,
  input  wire logic        i_lookup_req,
  input  wire logic [15:0] i_lookup_dac,
  input  wire logic        i_cal_enter,
  input  wire logic        i_freq_valid,
  input  wire logic [15:0] i_freq_mhz,
  input  wire logic        i_abort,
  input  wire logic        i_exit,
  input  wire logic        i_search_done,
  input  wire logic        i_search_ok,
  input  wire logic [15:0] i_search_dac,
  output logic             o_lookup_valid,
  output logic [15:0]      o_lookup_freq,
  output logic             o_error_valid,
  output logic [7:0]       o_error_code,
  output logic             o_search_start,
  output logic             o_cal_active,
  output logic [7:0]       o_point_prompt_code,
  output logic [7:0]       o_bus_status
);
  yig_cal_pkg::state_t state_reg;
  logic [7:0]  idx_reg;
  logic [7:0]  pos_reg;
  logic [7:0]  count_reg;
  logic [15:0] lk_d_reg;
  logic [15:0] prev_y_reg;
  logic [15:0] prev_d_reg;
  logic        have_prev_reg;
  logic [15:0] new_y_reg;
  logic [15:0] dac_reg;
  logic [15:0] y1_reg;
  logic [15:0] d1_reg;
  logic [15:0] y2_reg;
  logic [15:0] d2_reg;
  logic [15:0] yp_reg;
  logic [15:0] dp_reg;
  logic [15:0] yl_reg;
  logic [15:0] dl_reg;

  table_mem_if mem_if ();

  yig_table_mem u_mem
  (
    .i_clk (i_clk),
    .bus   (mem_if.mem)
  );

  // =======================================================
  // Arithmetic helpers, signed so truncation goes toward zero
  function automatic logic [15:0] interp
  (
    input logic [15:0] d,
    input logic [15:0] dp,
    input logic [15:0] yp,
    input logic [15:0] dq,
    input logic [15:0] yq
  );
    logic signed [35:0] num;
    logic signed [35:0] den;
    logic signed [35:0] res;
    num = ($signed({20'h0, d}) - $signed({20'h0, dp}))
        * ($signed({20'h0, yq}) - $signed({20'h0, yp})); // [RULE7]
    den = $signed({20'h0, dq}) - $signed({20'h0, dp});
    res = (den == 36'sh0) ? 36'sh0 : num / den; // [RULE23]
    res = res + $signed({20'h0, yp}); // [RULE6]
    return res[15:0];
  endfunction

  function automatic logic [15:0] extrap
  (
    input logic [15:0] d,
    input logic [15:0] ya,
    input logic [15:0] da,
    input logic [15:0] yb,
    input logic [15:0] db
  );
    logic signed [35:0] num;
    logic signed [35:0] den;
    logic signed [35:0] res;
    num = $signed({20'h0, d})
          * ($signed({20'h0, yb}) - $signed({20'h0, ya}))
        + $signed({20'h0, ya}) * $signed({20'h0, db})
        - $signed({20'h0, yb}) * $signed({20'h0, da}); // [RULE16]
    den = $signed({20'h0, db}) - $signed({20'h0, da});
    res = (den == 36'sh0) ? 36'sh0 : num / den; // [RULE23]
    return res[15:0];
  endfunction

  // =======================================================
  // Decode of the current table entry and session checks
  wire logic [15:0] ent_y     = mem_if.rdata[31:16]; // [RULE1]
  wire logic [15:0] ent_d     = mem_if.rdata[15:0];
  wire logic        ent_end   = mem_if.rdata == yig_cal_pkg::END_MARK;
  // End mark is never a match nor an upper neighbour
  wire logic        lk_hit    = !ent_end && ent_d == lk_d_reg; // [RULE5]
  wire logic        lk_brk    = !ent_end && have_prev_reg
                                && prev_d_reg < lk_d_reg
                                && lk_d_reg < ent_d; // [RULE6]
  wire logic        lk_last   =
    idx_reg == 8'(yig_cal_pkg::MAX_ENTRIES - 1); // [RULE3]
  wire logic        lk_fail   = !lk_hit && !lk_brk
                                && (ent_end || lk_last); // [RULE8]
  wire logic [15:0] in_y      =
    i_freq_mhz >> yig_cal_pkg::FREQ_SHIFT; // [RULE2]
  wire logic        ord_ok    = count_reg == 8'h00
                                || in_y > yl_reg; // [RULE13]
  wire logic        cnt_ok    =
    count_reg < 8'(yig_cal_pkg::MAX_POINTS); // [RULE12]
  wire logic        accept    = i_freq_valid && ord_ok && cnt_ok;
  wire logic        exit_ok   =
    count_reg >= 8'(yig_cal_pkg::MIN_POINTS); // [RULE14]
  wire logic        prot_ok   = i_calibration_protect_switch;
  wire logic        in_wait   = state_reg == yig_cal_pkg::ST_CAL_WAIT;
  wire logic        srch_ok   = state_reg == yig_cal_pkg::ST_CAL_SRCH
                                && i_search_done && i_search_ok;
  wire logic        srch_bad  = state_reg == yig_cal_pkg::ST_CAL_SRCH
                                && i_search_done && !i_search_ok;
  wire logic [15:0] ext_lo    = extrap(yig_cal_pkg::DEFAULT_LO,
                                  y1_reg, d1_reg, y2_reg, d2_reg);
  wire logic [15:0] ext_hi    = extrap(yig_cal_pkg::DEFAULT_HI,
                                  yp_reg, dp_reg, yl_reg, dl_reg);
  wire logic [15:0] lk_interp = interp(lk_d_reg, prev_d_reg,
                                  prev_y_reg, ent_d, ent_y);

  // =======================================================
  // Memory address, write enable and write data selection
  wire logic        st_init  = state_reg == yig_cal_pkg::ST_CAL_INIT;
  wire logic        st_hi    = state_reg == yig_cal_pkg::ST_CAL_HI;
  wire logic        st_store = state_reg == yig_cal_pkg::ST_CAL_STORE;
  wire logic        st_elo   = state_reg == yig_cal_pkg::ST_EXT_LO;
  wire logic        st_ehi   = state_reg == yig_cal_pkg::ST_EXT_HI;
  wire logic        st_cprd  = state_reg == yig_cal_pkg::ST_CP_RD;
  wire logic        st_cpwr  = state_reg == yig_cal_pkg::ST_CP_WR;
  wire logic        st_mark  = state_reg == yig_cal_pkg::ST_CP_MARK;
  wire logic        st_lkrd  = state_reg == yig_cal_pkg::ST_LK_RD;
  wire logic        use_cm   = st_cpwr || st_mark || st_lkrd;
  wire logic [7:0]  mem_idx  =
    (st_init || st_elo)      ? 8'h00 :
    (st_cprd || st_cpwr || st_lkrd) ? idx_reg :
    st_store                 ? pos_reg - 8'h01 :
    st_mark                  ? pos_reg + 8'h01 : pos_reg;
  wire logic        cm_write = (st_cpwr || st_mark) && prot_ok; // [RULE18]
  wire logic        wk_write = st_init || st_hi || st_store
                               || st_elo || st_ehi
                               || (in_wait && accept);

  assign mem_if.addr  = (use_cm ? yig_cal_pkg::COMMIT_BASE
                                : yig_cal_pkg::WORK_BASE)
                        + {2'b00, mem_idx}; // [RULE17]
  assign mem_if.we    = cm_write || wk_write;
  assign mem_if.wdata =
    st_init  ? {yig_cal_pkg::DEFAULT_LO, yig_cal_pkg::DEFAULT_LO} :
    st_hi    ? {yig_cal_pkg::DEFAULT_HI, yig_cal_pkg::DEFAULT_HI} :
    st_store ? {new_y_reg, dac_reg} :
    st_elo   ? {ext_lo, yig_cal_pkg::DEFAULT_LO} : // [RULE4]
    st_ehi   ? {ext_hi, yig_cal_pkg::DEFAULT_HI} : // [RULE4]
    st_cpwr  ? mem_if.rdata :
    st_mark  ? yig_cal_pkg::END_MARK :
               {in_y, yig_cal_pkg::DEFAULT_LO}; // [RULE10]

  // =======================================================
  // Controller sequence
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg      <= yig_cal_pkg::ST_IDLE;
      idx_reg        <= 8'h00;
      pos_reg        <= 8'h00;
      count_reg      <= 8'h00;
      lk_d_reg       <= 16'h0000;
      have_prev_reg  <= 1'b0;
      o_lookup_valid <= 1'b0;
      o_lookup_freq  <= 16'h0000;
      o_error_valid  <= 1'b0;
      o_error_code   <= 8'h00;
      o_search_start <= 1'b0;
      o_cal_active   <= 1'b0;
      o_point_prompt_code <= yig_cal_pkg::PROMPT_NONE;
      o_bus_status   <= 8'h00;
    end
    else
    begin
      o_lookup_valid <= 1'b0;
      o_error_valid  <= 1'b0;
      o_search_start <= 1'b0;
      unique case (state_reg)
        yig_cal_pkg::ST_IDLE:
        begin
          have_prev_reg <= 1'b0;
          idx_reg       <= 8'h00;
          if (i_cal_enter)
          begin
            state_reg           <= yig_cal_pkg::ST_CAL_INIT;
            o_cal_active        <= 1'b1;
            count_reg           <= 8'h00;
            pos_reg             <= 8'h01; // [RULE9]
            o_point_prompt_code <= yig_cal_pkg::PROMPT_FIRST; // [RULE19]
          end
          else if (i_lookup_req)
          begin
            lk_d_reg  <= i_lookup_dac;
            state_reg <= yig_cal_pkg::ST_LK_RD;
          end
        end
        yig_cal_pkg::ST_LK_RD:
          state_reg <= yig_cal_pkg::ST_LK_CHK;
        yig_cal_pkg::ST_LK_CHK:
        begin
          if (lk_hit || lk_brk)
          begin
            o_lookup_valid <= 1'b1;
            o_lookup_freq  <= lk_hit ? ent_y : lk_interp; // [RULE5]
            state_reg      <= yig_cal_pkg::ST_IDLE;
          end
          else if (lk_fail)
          begin
            o_error_valid <= 1'b1;
            o_error_code  <= yig_cal_pkg::ERR_TABLE; // [RULE8]
            state_reg     <= yig_cal_pkg::ST_IDLE;
          end
          else
          begin
            have_prev_reg <= 1'b1;
            idx_reg       <= idx_reg + 8'h01;
            state_reg     <= yig_cal_pkg::ST_LK_RD;
          end
        end
        yig_cal_pkg::ST_CAL_INIT:
          state_reg <= yig_cal_pkg::ST_CAL_HI;
        yig_cal_pkg::ST_CAL_HI:
        begin
          // Upper default rewritten one place higher
          state_reg <= (count_reg == 8'h00 && pos_reg == 8'h01)
                       ? yig_cal_pkg::ST_CAL_WAIT
                       : yig_cal_pkg::ST_CAL_SRCH;
          o_search_start <= !(count_reg == 8'h00
                              && pos_reg == 8'h01); // [RULE11]
        end
        yig_cal_pkg::ST_CAL_WAIT:
        begin
          if (i_abort || (i_freq_valid && !(ord_ok && cnt_ok)))
          begin
            state_reg    <= yig_cal_pkg::ST_IDLE; // [RULE14]
            o_cal_active <= 1'b0;
            o_bus_status[yig_cal_pkg::READY_BIT] <= 1'b0;
          end
          else if (i_exit)
          begin
            state_reg <= (exit_ok && prot_ok) ? yig_cal_pkg::ST_EXT_LO
                                              : yig_cal_pkg::ST_IDLE;
            o_cal_active <= exit_ok && prot_ok; // [RULE21]
            o_bus_status[yig_cal_pkg::READY_BIT] <= 1'b0;
          end
          else if (accept)
          begin
            new_y_reg <= in_y;
            pos_reg   <= pos_reg + 8'h01; // [RULE10]
            state_reg <= yig_cal_pkg::ST_CAL_HI;
            o_bus_status[yig_cal_pkg::READY_BIT] <= 1'b0;
          end
        end
        yig_cal_pkg::ST_CAL_SRCH:
        begin
          if (i_abort || srch_bad)
          begin
            state_reg     <= yig_cal_pkg::ST_IDLE; // [RULE14]
            o_cal_active  <= 1'b0;
            o_error_valid <= srch_bad;
            o_error_code  <= srch_bad ? yig_cal_pkg::ERR_CENTER
                                      : o_error_code; // [RULE20]
          end
          else if (srch_ok)
          begin
            dac_reg   <= i_search_dac; // [RULE11]
            state_reg <= yig_cal_pkg::ST_CAL_STORE;
            o_bus_status[yig_cal_pkg::READY_BIT] <= 1'b1; // [RULE22]
            o_point_prompt_code <= o_point_prompt_code + 8'h01;
          end
        end
        yig_cal_pkg::ST_CAL_STORE:
        begin
          count_reg <= count_reg + 8'h01;
          state_reg <= yig_cal_pkg::ST_CAL_WAIT;
        end
        yig_cal_pkg::ST_EXT_LO:
          state_reg <= yig_cal_pkg::ST_EXT_HI; // [RULE15]
        yig_cal_pkg::ST_EXT_HI:
        begin
          idx_reg   <= 8'h00;
          state_reg <= yig_cal_pkg::ST_CP_RD; // [RULE15]
        end
        yig_cal_pkg::ST_CP_RD:
          state_reg <= yig_cal_pkg::ST_CP_WR;
        yig_cal_pkg::ST_CP_WR:
        begin
          idx_reg   <= idx_reg + 8'h01;
          state_reg <= (idx_reg == pos_reg) ? yig_cal_pkg::ST_CP_MARK
                                            : yig_cal_pkg::ST_CP_RD;
        end
        yig_cal_pkg::ST_CP_MARK:
        begin
          state_reg    <= yig_cal_pkg::ST_IDLE; // [RULE17]
          o_cal_active <= 1'b0;
        end
      endcase
    end
  end

  // =======================================================
  // Measured point history for end extrapolation
  always_ff @(posedge i_clk)
  begin
    if (st_store)
    begin
      if (count_reg == 8'h00)
      begin
        y1_reg <= new_y_reg;
        d1_reg <= dac_reg;
      end
      if (count_reg == 8'h01)
      begin
        y2_reg <= new_y_reg;
        d2_reg <= dac_reg;
      end
      yp_reg <= yl_reg; // [RULE16]
      dp_reg <= dl_reg;
      yl_reg <= new_y_reg;
      dl_reg <= dac_reg;
    end
    prev_y_reg <= (state_reg == yig_cal_pkg::ST_LK_CHK) ? ent_y
                                                        : prev_y_reg;
    prev_d_reg <= (state_reg == yig_cal_pkg::ST_LK_CHK) ? ent_d
                                                        : prev_d_reg;
  end

  // =======================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_prompt_start;
    (state_reg == yig_cal_pkg::ST_IDLE && i_cal_enter)
      |=> o_point_prompt_code == yig_cal_pkg::PROMPT_FIRST
          && o_cal_active;
  endproperty
  a_prompt_start: assert property (p_prompt_start) // [RULE19]
    else $error("prompt not started at one");

  property p_prompt_step;
    srch_ok |=> o_point_prompt_code == $past(o_point_prompt_code) + 8'h01;
  endproperty
  a_prompt_step: assert property (p_prompt_step) // [RULE19]
    else $error("prompt did not advance");

  property p_center_err;
    srch_bad |=> o_error_valid && o_error_code == yig_cal_pkg::ERR_CENTER
                 && !o_cal_active;
  endproperty
  a_center_err: assert property (p_center_err) // [RULE20]
    else $error("centring failure not reported");

  property p_ready;
    srch_ok |=> o_bus_status[0] ##1 (o_bus_status[0] && in_wait);
  endproperty
  a_ready: assert property (p_ready) // [RULE22]
    else $error("ready status not shown");

  property p_protect;
    (mem_if.we && use_cm) |-> i_calibration_protect_switch;
  endproperty
  a_protect: assert property (p_protect) // [RULE18]
    else $error("table written while protected");

  property p_half;
    (in_wait && accept) |-> mem_if.we
      && mem_if.wdata[31:16] == i_freq_mhz[15:1];
  endproperty
  a_half: assert property (p_half) // [RULE2]
    else $error("frequency not halved");

  property p_init;
    st_init |-> mem_if.wdata == 32'h0000_0000
      ##1 (mem_if.we && mem_if.wdata == 32'h3fff_3fff);
  endproperty
  a_init: assert property (p_init) // [RULE9]
    else $error("default entries wrong");

  property p_table_err;
    (state_reg == yig_cal_pkg::ST_LK_CHK && lk_fail)
      |=> o_error_valid && o_error_code == yig_cal_pkg::ERR_TABLE
          && !o_lookup_valid;
  endproperty
  a_table_err: assert property (p_table_err) // [RULE8]
    else $error("table error not raised");

  property p_order;
    (in_wait && i_freq_valid && !ord_ok && !i_abort && !i_exit)
      |=> state_reg == yig_cal_pkg::ST_IDLE ##1 !mem_if.we;
  endproperty
  a_order: assert property (p_order) // [RULE14]
    else $error("bad order did not abort");

  c_hit:    cover property (state_reg == yig_cal_pkg::ST_LK_CHK && lk_hit);
  c_interp: cover property (state_reg == yig_cal_pkg::ST_LK_CHK && lk_brk);
  c_commit: cover property (st_mark && prot_ok);
endmodule // yig_dac_correction_table

// *** sim/search_engine_model.sv ***
// Behavioural sweep and centring engine that answers the table controller
module search_engine_model
(
  input  wire logic        i_clk,
  input  wire logic        i_start,
  input  wire logic        i_ok,
  input  wire logic [15:0] i_dac,
  input  wire logic [3:0]  i_delay,
  output logic             o_done,
  output logic             o_ok,
  output logic [15:0]      o_dac
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] count_reg = 5'h00;
  logic       busy_reg  = 1'b0;
  // ========================================================
  // Idle values of the result lines
  initial
  begin
    o_done = 1'b0;
    o_ok   = 1'b0;
    o_dac  = 16'h5a5a;
  end
  // Search runs a set number of cycles, then reports once
  always @(posedge i_clk)
  begin
    o_done <= 1'b0;
    if (o_done)
    begin
      o_ok  <= ~o_ok;  // Results do not hold after the pulse
      o_dac <= ~o_dac;
    end
    if (i_start)
    begin
      busy_reg  <= 1'b1;
      count_reg <= {1'b0, i_delay};
    end
    else if (busy_reg && count_reg == 5'h00)
    begin
      busy_reg <= 1'b0;
      o_done   <= 1'b1;
      o_ok     <= i_ok;
      o_dac    <= i_dac;
    end
    else if (busy_reg)
      count_reg <= count_reg - 5'h01;
  end
endmodule // search_engine_model

// *** sim/tb_top.sv ***
// Self-checking bench of the YIG DAC correction table
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        prot, req, enter, fval, abort_p, exit_p;
  logic        s_done, s_ok, s_cfg_ok, lk_valid, err_valid;
  logic        s_start, active;
  logic [15:0] ldac, fmhz, s_dac, s_cfg_dac, lk_freq;
  logic [7:0]  err_code, prompt, status;
  logic [3:0]  s_delay;
  logic [4:0]  evt;
  int          failures = 0;
  int          checked = 0;
  // ========================================================
  // Clock, design and partner
  always #2.5 i_clk = ~i_clk;
  assign evt = {~active, lk_valid | err_valid, err_valid, status[0], s_start};
  yig_dac_correction_table DUT
  (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_calibration_protect_switch(prot),
    .i_lookup_req(req), .i_lookup_dac(ldac), .i_cal_enter(enter),
    .i_freq_valid(fval), .i_freq_mhz(fmhz), .i_abort(abort_p),
    .i_exit(exit_p), .i_search_done(s_done), .i_search_ok(s_ok),
    .i_search_dac(s_dac), .o_lookup_valid(lk_valid),
    .o_lookup_freq(lk_freq), .o_error_valid(err_valid),
    .o_error_code(err_code), .o_search_start(s_start),
    .o_cal_active(active), .o_point_prompt_code(prompt),
    .o_bus_status(status)
  );
  search_engine_model engine
  (
    .i_clk(i_clk), .i_start(s_start), .i_ok(s_cfg_ok), .i_dac(s_cfg_dac),
    .i_delay(s_delay), .o_done(s_done), .o_ok(s_ok), .o_dac(s_dac)
  );
  // ========================================================
  // Shared helpers
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wait_evt(input int b);
    int i = 0;
    while (evt[b] !== 1'b1)
    begin
      tick(1);
      i++;
      if (i > 3000)
      begin
        failures++;
        $display("wrong value event %0d expected 1 seen timeout", b);
        end_of_test();
      end
    end
  endtask
  task automatic cal_enter();
    enter = 1'b1;
    tick(1);
    enter = 1'b0;
    tick(2);
    chk("prompt", 16'h0001, {8'h00, prompt});
    chk("active", 16'h0001, {15'h0000, active});
  endtask
  task automatic cal_point(input logic [15:0] mhz, input logic [15:0] dac,
                           input logic ok, input logic [7:0] pr);
    s_cfg_ok = ok;
    s_cfg_dac = dac;
    fmhz = mhz;
    fval = 1'b1;
    tick(1);
    fval = 1'b0;
    fmhz = ~mhz;
    wait_evt(0);
    wait_evt(ok ? 1 : 2);
    if (ok)
    begin
      chk("status", 16'h0001, {8'h00, status});
      chk("prompt", {8'h00, pr}, {8'h00, prompt});
    end
    else
      chk("err code", 16'h002a, {8'h00, err_code});
    tick(2);
  endtask
  task automatic strobe_end(input logic abt);
    abort_p = abt;
    exit_p = ~abt;
    tick(1);
    abort_p = 1'b0;
    exit_p = 1'b0;
    wait_evt(4);
  endtask
  task automatic lookup(input logic [15:0] d, input logic [15:0] exp,
                        input logic err);
    ldac = d;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    wait_evt(3);
    chk("lk valid", {15'h0000, ~err}, {15'h0000, lk_valid});
    chk("lk result", exp, err ? {8'h00, err_code} : lk_freq);
  endtask
  // ========================================================
  // Scenarios
  task automatic test_session();
    s_delay = 4'h0;
    cal_enter();
    cal_point(16'd1000, 16'h0400, 1'b1, 8'h02);
    s_delay = 4'hc;
    cal_point(16'd1300, 16'h0800, 1'b1, 8'h03);
    cal_point(16'd10000, 16'h2000, 1'b1, 8'h04);
    strobe_end(1'b0);
    $display("test session done");
  endtask
  task automatic test_lookup();
    lookup(16'h0800, 16'h028a, 1'b0);
    lookup(16'h0500, 16'h0219, 1'b0);
    lookup(16'h1000, 16'h0834, 1'b0);
    lookup(16'h0000, 16'h015e, 1'b0);
    lookup(16'h3fff, 16'h2a2f, 1'b0);
    lookup(16'h4000, 16'h0028, 1'b1);
    $display("test lookup done");
  endtask
  task automatic test_refused();
    cal_enter();
    cal_point(16'd2000, 16'h0c00, 1'b1, 8'h02);
    fmhz = 16'd1500;
    fval = 1'b1;
    tick(1);
    fval = 1'b0;
    tick(3);
    chk("active", 16'h0000, {15'h0000, active});
    cal_enter();
    cal_point(16'd2000, 16'h0c00, 1'b1, 8'h02);
    cal_point(16'd3000, 16'h0e00, 1'b0, 8'h00);
    chk("active", 16'h0000, {15'h0000, active});
    cal_enter();
    cal_point(16'd2000, 16'h0c00, 1'b1, 8'h02);
    cal_point(16'd3000, 16'h0e00, 1'b1, 8'h03);
    strobe_end(1'b1);
    cal_enter();
    cal_point(16'd2000, 16'h0c00, 1'b1, 8'h02);
    strobe_end(1'b0);
    cal_enter();
    cal_point(16'd2000, 16'h0c00, 1'b1, 8'h02);
    cal_point(16'd3000, 16'h0e00, 1'b1, 8'h03);
    prot = 1'b0;
    strobe_end(1'b0);
    prot = 1'b1;
    lookup(16'h0500, 16'h0219, 1'b0);
    $display("test refused done");
  endtask
  // ========================================================
  // Main sequence
  initial
  begin
    {prot, req, enter, fval, abort_p, exit_p, s_cfg_ok} = 7'h41;
    {ldac, fmhz, s_cfg_dac} = 48'h0;
    s_delay = 4'h0;
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    i_nrst = 1'b1;
    chk("status", 16'h0000, {8'h00, status});
    test_session();
    test_lookup();
    test_refused();
    end_of_test();
  end
endmodule // tb_top
